// File: dac_front_params.svh
// Constants for the serial converter front end
`ifndef DAC_FRONT_PARAMS_SVH
`define DAC_FRONT_PARAMS_SVH
`define FRAME_BITS 24
`define CODE_BITS 18
`define CNT_W 5
`define PIN_COUNT 7
`define RESET_CODE_LOW 24'h000000
`define RESET_CODE_HIGH 24'h020000
`define POR_CYCLES 3'h5
// Positions of the pins in the synchroniser vector
`define PIN_CS 0
`define PIN_LOAD 1
`define PIN_SLEEP 2
`define PIN_RSEL 3
`define PIN_RMODE 4
`define PIN_FMT 5
`define PIN_HWRST 6
`endif

// File: dac_front_pkg.sv
// Types for the serial converter front end
`include "dac_front_params.svh"
package dac_front_pkg;
   typedef logic [`PIN_COUNT-1:0] pin_vec_t;
   typedef struct packed {
      pin_vec_t s1;
      pin_vec_t s2;
      pin_vec_t s3;
      pin_vec_t filt;
      logic [2:0] por_cnt;
      logic [`FRAME_BITS-1:0] input_reg;
      logic [`CODE_BITS-1:0] latch;
   } core_state_t;
   typedef struct packed {
      logic [`FRAME_BITS-1:0] shift;
      logic [`CNT_W-1:0] cnt;
   } link_state_t;
endpackage

// File: serial_dac_input_logic.sv
// Serial link, double-buffered code registers and reset handling of the converter
//
// Overview of operation
// - Sleep pin keeps registers and link alive
// - Reset pin low forces both registers
// - After reset release, registers keep reset value
// - Power-on loads both registers with selected value
// - Reset code 00000h or 20000h by select
// - Rising sclk samples sdi, 24 edges needed
// - Chip select high: link ignored, sdo floats
// - Short frame leaves input register unchanged
// - Long frame keeps final 24 bits
// - Select rising edge copies shift into input
// - MSB first; low 18 bits are code
// - Readback mode shifts input register out
// - Readback beyond 24 bits sends zeros
// - Chain mode passes excess bits to sdo
// - Chain sdo changes on falling sclk
// - Load pin high holds converter latch
// - Load pin low: latch follows input
// - Load pin falling loads latch
// - Shift register never reset
`timescale 1ns/10ps
`include "dac_front_params.svh"
module serial_dac_input_logic
   import dac_front_pkg::*;
#(
   parameter int FRAME_BITS = `FRAME_BITS,
   parameter int CODE_BITS = `CODE_BITS
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic ce,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdi,
   output logic sdo_out,
   output logic sdo_oe_n,
   input wire logic latch_load_n,
   input wire logic sleep_request,
   input wire logic reset_value_select,
   input wire logic readout_mode_select,
   input wire logic code_format_select,
   input wire logic hw_reset_n,
   output logic [`CODE_BITS-1:0] dac_code,
   output logic [`FRAME_BITS-1:0] input_word,
   output logic power_down,
   output logic code_format
);
   if (FRAME_BITS != `FRAME_BITS || CODE_BITS != `CODE_BITS) begin : g_check
      $error("Only the 24-bit frame with an 18-bit code is supported");
   end

   core_state_t core_reg;
   core_state_t core_next;
   link_state_t link_reg;
   link_state_t link_next;
   logic armed_reg;
   logic sdo_reg;
   pin_vec_t pins;
   logic cs_rise;
   logic frame_ok;
   logic reset_apply;
   logic [`FRAME_BITS-1:0] reset_code;
   logic [`CNT_W-1:0] out_idx;

   assign pins = {hw_reset_n, code_format_select, readout_mode_select, reset_value_select,
                  sleep_request, latch_load_n, cs_n};

   // ---------------- System clock domain ----------------
   // Link state below is only read here after the select pin has been high for
   // several cycles, so the shift register and count are quiet by then.
   assign frame_ok = (link_reg.cnt == `CNT_W'(`FRAME_BITS));
   assign reset_code = core_reg.filt[`PIN_RSEL] ? `RESET_CODE_HIGH : `RESET_CODE_LOW;
   assign reset_apply = (core_reg.por_cnt != 3'h0) || !core_reg.filt[`PIN_HWRST];

   always_comb begin
      core_next = core_reg;
      core_next.s1 = pins;
      core_next.s2 = core_reg.s1;
      core_next.s3 = core_reg.s2;
      // A change counts once the second and third stages agree
      core_next.filt = (~(core_reg.s2 ^ core_reg.s3) & core_reg.s3)
                     | ((core_reg.s2 ^ core_reg.s3) & core_reg.filt);
      cs_rise = core_next.filt[`PIN_CS] && !core_reg.filt[`PIN_CS];
      if (core_reg.por_cnt != 3'h0) begin
         core_next.por_cnt = core_reg.por_cnt - 3'h1;
      end
      if (reset_apply) begin
         core_next.input_reg = reset_code;
      end else if (cs_rise && frame_ok) begin
         core_next.input_reg = link_reg.shift;
      end
      // Short frames fall through and keep the previous word
      // Sleep does not touch the registers or the link
      if (reset_apply) begin
         core_next.latch = reset_code[`CODE_BITS-1:0];
      end else if (!core_reg.filt[`PIN_LOAD]) begin
         core_next.latch = core_next.input_reg[`CODE_BITS-1:0];
      end
      // Load pin high: latch holds
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         // Idle levels: select, load and reset pin high, straps low
         core_reg.s1 <= `PIN_COUNT'h43;
         core_reg.s2 <= `PIN_COUNT'h43;
         core_reg.s3 <= `PIN_COUNT'h43;
         core_reg.filt <= `PIN_COUNT'h43;
         // Window long enough for the strap pins to pass the filter
         core_reg.por_cnt <= `POR_CYCLES;
         core_reg.input_reg <= `RESET_CODE_LOW;
         core_reg.latch <= `CODE_BITS'h00000;
      end else if (ce) begin
         core_reg <= core_next;
      end
   end

   assign dac_code = core_reg.latch;
   assign input_word = core_reg.input_reg;
   assign power_down = core_reg.filt[`PIN_SLEEP];
   assign code_format = core_reg.filt[`PIN_FMT];

   // Register checks for the clk domain; each check on the core registers is gated on ce
   a_por_window_code: assert property (@(posedge clk) disable iff (sys_rst)
      (ce && core_reg.por_cnt != 3'h0) |=> (input_word == $past(reset_code)))
      else $error("Power-on window did not apply the reset code");

   a_por_counts_down: assert property (@(posedge clk) disable iff (sys_rst)
      (ce && core_reg.por_cnt != 3'h0) |=> (core_reg.por_cnt == $past(core_reg.por_cnt) - 3'h1))
      else $error("Power-on window did not count down");

   a_latch_reset_value: assert property (@(posedge clk) disable iff (sys_rst)
      (ce && reset_apply) |=> (dac_code == $past(reset_code[`CODE_BITS-1:0])))
      else $error("Latch did not take the reset code");

   a_reset_zero_code: assert property (@(posedge clk) disable iff (sys_rst)
      (ce && reset_apply && !core_reg.filt[`PIN_RSEL]) |=> (input_word == `RESET_CODE_LOW))
      else $error("Low select did not give the zero code");

   a_reset_mid_code: assert property (@(posedge clk) disable iff (sys_rst)
      (ce && reset_apply && core_reg.filt[`PIN_RSEL]) |=> (input_word == `RESET_CODE_HIGH))
      else $error("High select did not give the midscale code");

   a_hw_latch_forced: assert property (@(posedge clk) disable iff (sys_rst)
      (ce && !core_reg.filt[`PIN_HWRST]) |=> (dac_code == $past(reset_code[`CODE_BITS-1:0])))
      else $error("Reset pin did not force the latch");

   a_hw_release_keeps: assert property (@(posedge clk) disable iff (sys_rst)
      (ce && $rose(core_reg.filt[`PIN_HWRST]) && core_reg.por_cnt == 3'h0 && !cs_rise) |=> $stable(input_word))
      else $error("Input register moved on reset release");

   a_frame_needs_rise: assert property (@(posedge clk) disable iff (sys_rst)
      (ce && !reset_apply && !cs_rise) |=> $stable(input_word))
      else $error("Input register changed without a frame end");

   a_sleep_frame_loads: assert property (@(posedge clk) disable iff (sys_rst)
      (ce && power_down && !reset_apply && cs_rise && frame_ok) |=> (input_word == $past(link_reg.shift)))
      else $error("Frame lost while asleep");

   a_load_high_frame: assert property (@(posedge clk) disable iff (sys_rst)
      (ce && !reset_apply && core_reg.filt[`PIN_LOAD] && cs_rise && frame_ok) |=> $stable(dac_code))
      else $error("Frame reached the held latch");

   a_sync_latch_frame: assert property (@(posedge clk) disable iff (sys_rst)
      (ce && !reset_apply && !core_reg.filt[`PIN_LOAD] && cs_rise && frame_ok)
      |=> (dac_code == $past(link_reg.shift[`CODE_BITS-1:0])))
      else $error("Transparent latch missed the new frame");

   // Shift register is never reset, so identity compares let unknowns match
   a_link_frozen_idle: assert property (@(posedge clk) disable iff (sys_rst)
      (cs_n && $past(cs_n)) |-> (link_reg === $past(link_reg)))
      else $error("Link state moved while select high");

   // ---------------- Link clock domain ----------------
   // Set while the select pin is high, so the first edge of a frame restarts
   // the count without needing any edge outside the frame.
   always_ff @(posedge sclk or posedge cs_n) begin
      if (cs_n) begin
         armed_reg <= 1'b1;
      end else begin
         armed_reg <= 1'b0;
      end
   end

   always_comb begin
      link_next = link_reg;
      link_next.shift = {link_reg.shift[`FRAME_BITS-2:0], sdi};
      if (armed_reg) begin
         link_next.cnt = `CNT_W'(1);
      end else if (link_reg.cnt != `CNT_W'(`FRAME_BITS)) begin
         link_next.cnt = link_reg.cnt + `CNT_W'(1);
      end
   end

   // No reset on purpose: the shift register survives every reset
   always_ff @(posedge sclk) begin
      if (!cs_n) begin
         link_reg <= link_next;
      end
   end

   // Mode and input register are quasi-static to this domain while a frame runs
   assign out_idx = `CNT_W'(`FRAME_BITS - 1) - link_reg.cnt;

   always_ff @(negedge sclk) begin
      if (!cs_n) begin
         if (!core_reg.filt[`PIN_RMODE]) begin
            sdo_reg <= link_reg.shift[`FRAME_BITS-1];
         end else if (link_reg.cnt < `CNT_W'(`FRAME_BITS)) begin
            sdo_reg <= core_reg.input_reg[out_idx];
         end else begin
            sdo_reg <= 1'b0;
         end
      end
   end

   // Before the first rising edge the first bit is presented directly
   assign sdo_out = !armed_reg ? sdo_reg :
                    (core_reg.filt[`PIN_RMODE] ? core_reg.input_reg[`FRAME_BITS-1]
                                               : link_reg.shift[`FRAME_BITS-1]);
   assign sdo_oe_n = cs_n;

   // Link checks, sampled on the link clock inside frames only, except the sdo enable check, which runs on clk
   a_count_restarts: assert property (@(posedge sclk) disable iff (cs_n)
      armed_reg |=> (link_reg.cnt == `CNT_W'(1)))
      else $error("Bit count did not restart");

   a_count_saturates: assert property (@(posedge sclk) disable iff (cs_n)
      (!armed_reg && link_reg.cnt == `CNT_W'(`FRAME_BITS)) |=> (link_reg.cnt == `CNT_W'(`FRAME_BITS)))
      else $error("Bit count left saturation");

   a_oldest_bit_drops: assert property (@(posedge sclk) disable iff (cs_n)
      1'b1 |=> (link_reg.shift[`FRAME_BITS-1] === $past(link_reg.shift[`FRAME_BITS-2])))
      else $error("Oldest bit not dropped");

   a_sleep_link_alive: assert property (@(posedge sclk) disable iff (cs_n)
      core_reg.filt[`PIN_SLEEP] |=> (link_reg.shift[0] == $past(sdi)))
      else $error("Link stopped while asleep");

   a_readback_first: assert property (@(posedge sclk) disable iff (cs_n)
      (armed_reg && core_reg.filt[`PIN_RMODE]) |-> (sdo_out == input_word[`FRAME_BITS-1]))
      else $error("Readback first bit wrong");

   a_readback_bits: assert property (@(posedge sclk) disable iff (cs_n)
      (!armed_reg && core_reg.filt[`PIN_RMODE] && link_reg.cnt < `CNT_W'(`FRAME_BITS))
      |-> (sdo_out == input_word[`CNT_W'(`FRAME_BITS - 1) - link_reg.cnt]))
      else $error("Readback bit wrong");

   a_chain_sdo_bit: assert property (@(posedge sclk) disable iff (cs_n)
      !core_reg.filt[`PIN_RMODE] |-> (sdo_out === link_reg.shift[`FRAME_BITS-1]))
      else $error("Chain output not the oldest bit");

   a_sdo_drives_frame: assert property (@(posedge clk)
      !cs_n |-> !sdo_oe_n)
      else $error("Sdo not driven inside a frame");

   // ---------------- Assertions ----------------
   a_hw_reset_value: assert property (@(posedge clk) disable iff (sys_rst)
      (ce && !core_reg.filt[`PIN_HWRST]) |=> (input_word == $past(reset_code)) && (dac_code == $past(reset_code[17:0])))
      else $error("Reset pin did not force the reset code");
   a_por_load_value: assert property (@(posedge clk)
      ($fell(sys_rst) && ce) [*1] ##0 (ce [*6]) |-> (input_word == reset_code))
      else $error("Power-on did not load the selected code");
   a_short_frame_kept: assert property (@(posedge clk) disable iff (sys_rst)
      (ce && !reset_apply && cs_rise && !frame_ok) |=> $stable(input_word))
      else $error("Short frame changed the input register");
   a_frame_load_word: assert property (@(posedge clk) disable iff (sys_rst)
      (ce && !reset_apply && cs_rise && frame_ok) |=> (input_word == $past(link_reg.shift)))
      else $error("Valid frame not copied on select rising");
   a_latch_held_high: assert property (@(posedge clk) disable iff (sys_rst)
      (ce && !reset_apply && core_reg.filt[`PIN_LOAD]) |=> $stable(dac_code))
      else $error("Latch changed while load pin high");
   a_latch_follows_in: assert property (@(posedge clk) disable iff (sys_rst)
      (ce && !reset_apply && !core_reg.filt[`PIN_LOAD]) |=> (dac_code == input_word[17:0]))
      else $error("Transparent latch not following input register");
   a_load_fall_takes: assert property (@(posedge clk) disable iff (sys_rst)
      (ce && !reset_apply && $fell(core_reg.filt[`PIN_LOAD])) |=> (dac_code == $past(input_word[17:0]))
      || (dac_code == input_word[17:0]))
      else $error("Load pin falling did not update latch");
   a_sleep_keeps_regs: assert property (@(posedge clk) disable iff (sys_rst)
      (ce && power_down && !reset_apply && !cs_rise && core_reg.filt[`PIN_LOAD]) |=> $stable(input_word)
      && $stable(dac_code))
      else $error("Sleep disturbed the registers");
   a_sdo_floats_idle: assert property (@(posedge clk)
      cs_n |-> sdo_oe_n)
      else $error("Sdo driven while select high");
   a_bit_count_step: assert property (@(posedge sclk) disable iff (cs_n)
      (!armed_reg && link_reg.cnt < `CNT_W'(`FRAME_BITS)) |=> (link_reg.cnt == $past(link_reg.cnt) + `CNT_W'(1)))
      else $error("Bit count did not advance");
   a_shift_takes_sdi: assert property (@(posedge sclk) disable iff (cs_n)
      1'b1 |=> (link_reg.shift[0] == $past(sdi)) && (link_reg.shift[23:1] === $past(link_reg.shift[22:0])))
      else $error("Shift register did not take sdi");
   a_readback_zero_tail: assert property (@(posedge sclk) disable iff (cs_n)
      (!armed_reg && core_reg.filt[`PIN_RMODE] && link_reg.cnt == `CNT_W'(`FRAME_BITS)) |-> !sdo_out)
      else $error("Readback tail is not zero");

   c_valid_frame: cover property (@(posedge clk) ce && cs_rise && frame_ok && !reset_apply);
   c_short_frame: cover property (@(posedge clk) ce && cs_rise && !frame_ok && !reset_apply);
   c_load_fall: cover property (@(posedge clk) ce && $fell(core_reg.filt[`PIN_LOAD]));
   c_readback_long: cover property (@(posedge sclk) !cs_n && core_reg.filt[`PIN_RMODE] && frame_ok);
   c_chain_long: cover property (@(posedge sclk) !cs_n && !core_reg.filt[`PIN_RMODE] && frame_ok);
endmodule

// File: spi_host_model.sv
// Host-side serial link controller model
`timescale 1ns/10ps
module spi_host_model (
   output logic sclk,
   output logic cs_n,
   output logic sdi,
   input wire logic sdo
);
   logic [47:0] rx;
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      sdi = 1'b0;
      rx = 48'h0;
   end
   // Clock runs only inside a frame; sdo is taken at each rising edge
   task automatic frame(input logic [47:0] word, input int nbits);
      cs_n = 1'b0;
      #17;
      for (int i = nbits - 1; i >= 0; i--) begin
         sdi = word[i];
         #15 sclk = 1'b1;
         rx = {rx[46:0], sdo};
         #15 sclk = 1'b0;
      end
      // Released data line flips so a stale bit cannot pass for a good one
      sdi = ~sdi;
      #20 cs_n = 1'b1;
   endtask
endmodule

// File: test_serial_dac_input_logic.sv
// Self-checking bench for the converter front end
`timescale 1ns/10ps
module test_serial_dac_input_logic;
   import dac_front_pkg::*;
   typedef struct {
      logic [47:0] word;
      int nbits;
      logic load_n;
      logic [23:0] exp_in;
      logic [17:0] exp_code;
   } row_t;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic latch_load_n = 1'b0;
   logic sleep_request = 1'b0;
   logic reset_value_select = 1'b1;
   logic readout_mode_select = 1'b0;
   logic code_format_select = 1'b0;
   logic hw_reset_n = 1'b1;
   logic sclk, cs_n, sdi, sdo_out, sdo_oe_n, power_down, code_format;
   logic [17:0] dac_code;
   logic [23:0] input_word;
   int err_total = 0;
   int samples_checked = 0;
   row_t rows [4] = '{
      '{48'hFC1234, 24, 1'b0, 24'hFC1234, 18'h01234},
      '{48'h00ABCD, 16, 1'b0, 24'hFC1234, 18'h01234},
      '{48'h112ABCDE, 32, 1'b0, 24'h2ABCDE, 18'h2BCDE},
      '{48'h03FFFF, 24, 1'b1, 24'h03FFFF, 18'h2BCDE}};
   serial_dac_input_logic #(.FRAME_BITS(24), .CODE_BITS(18)) dut (
      .clk(clk), .sys_rst(sys_rst), .ce(1'b1), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
      .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n), .latch_load_n(latch_load_n),
      .sleep_request(sleep_request), .reset_value_select(reset_value_select),
      .readout_mode_select(readout_mode_select), .code_format_select(code_format_select),
      .hw_reset_n(hw_reset_n), .dac_code(dac_code), .input_word(input_word),
      .power_down(power_down), .code_format(code_format));
   spi_host_model host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo_out));
   always #2.5 clk = ~clk;
   task automatic w(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic chk(input string name, input logic [47:0] exp, input logic [47:0] got);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      w(12);
      chk("por word", 48'h020000, input_word);
      chk("por code", 48'h20000, dac_code);
      chk("idle oe_n", 48'h1, sdo_oe_n);
      chk("format low", 48'h0, code_format);
      foreach (rows[i]) begin
         @(posedge clk) latch_load_n <= rows[i].load_n;
         host.frame(rows[i].word, rows[i].nbits);
         w(10);
         chk("word", rows[i].exp_in, input_word);
         chk("code", rows[i].exp_code, dac_code);
      end
      @(posedge clk) latch_load_n <= 1'b0;
      w(10);
      chk("load fall", 48'h3FFFF, dac_code);
      @(posedge clk) readout_mode_select <= 1'b1;
      w(10);
      host.frame(48'hFF0A0B0C, 32);
      w(10);
      chk("readback", {24'h03FFFF, 8'h00}, host.rx[31:0]);
      chk("rb word", 48'h0A0B0C, input_word);
      @(posedge clk) readout_mode_select <= 1'b0;
      w(10);
      host.frame(48'h123456ABCDEF, 48);
      w(10);
      chk("chain out", 48'h0A0B0C123456, host.rx);
      chk("chain word", 48'hABCDEF, input_word);
      @(posedge clk) begin
         sleep_request <= 1'b1;
         code_format_select <= 1'b1;
      end
      w(10);
      host.frame(48'h000155, 24);
      w(10);
      chk("sleep", 48'h1, power_down);
      chk("sleep word", 48'h000155, input_word);
      chk("format high", 48'h1, code_format);
      @(posedge clk) begin
         reset_value_select <= 1'b0;
         hw_reset_n <= 1'b0;
      end
      w(10);
      chk("hw word", 48'h0, input_word);
      chk("hw code", 48'h0, dac_code);
      @(posedge clk) hw_reset_n <= 1'b1;
      w(10);
      // Short frame after reset must not disturb the reset value
      host.frame(48'h00BEEF, 12);
      w(10);
      chk("after hw word", 48'h0, input_word);
      chk("after hw code", 48'h0, dac_code);
      final_report();
   end
   initial begin
      #100000;
      err_total++;
      final_report();
   end
endmodule
